// >>> logic/fsm_minmax_unit.sv
`timescale 1ns/10ps
// Summary of operation
// - Coprocessor disabled: unusable exception, no result.
// - Unimplemented format: reserved instruction exception.
// - Any signalling NaN raises invalid operation.
// - Both NaN: return first source unchanged.
// - One NaN: return the numeric source.
// - Max returns numerically greater value.
// - Min returns numerically smaller value.
// - Max magnitude; ties pick greater value.
// - Min magnitude; ties pick smaller value.
// - Signed zeros: largest +0, smallest -0.
// - Enabled invalid trap suppresses destination write.
// - Disabled trap: treat SNaN as quiet, unchanged.
// - Only unimplemented or invalid flags raised.
// - Operations present only from revision six.
module fsm_minmax_unit
  import fsm_pkg::*;
#(
  parameter int ARCH_REV = 6
) (
  // Clock and reset
  input  wire logic     CORE_CLK,
  input  wire logic     RST,
  // Control state from the processor
  input  wire logic     COP1_ENABLE,
  input  wire logic     INVALID_ENABLE,
  input  wire logic     DOUBLE_IMPL,
  // Issue
  input  wire logic     REQ_VALID,
  input  wire fsm_req_s REQ,
  // Answer
  output fsm_wb_s       WB,
  output logic          DONE,
  output fsm_exc_s      EXC
);

  initial begin
    if (ARCH_REV < 1) begin
      $error("ARCH_REV must be positive.");
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic is_op;
  logic is_dbl;
  logic fmt_ok;
  logic is_max;
  logic is_mag;

  always_comb begin
    is_op  = (REQ.funct == FSM_FN_MIN) || (REQ.funct == FSM_FN_SMALLEST_MAGNITUDE_OP) ||
             (REQ.funct == FSM_FN_MAX) || (REQ.funct == FSM_FN_LARGEST_MAGNITUDE_OP);
    is_op  = is_op && (ARCH_REV >= FSM_MIN_REV);
    is_dbl = (REQ.fmt == FSM_FMT_DOUBLE);
    fmt_ok = (REQ.fmt == FSM_FMT_SINGLE) || (is_dbl && DOUBLE_IMPL);
    is_max = (REQ.funct == FSM_FN_MAX) || (REQ.funct == FSM_FN_LARGEST_MAGNITUDE_OP);
    is_mag = (REQ.funct == FSM_FN_SMALLEST_MAGNITUDE_OP) || (REQ.funct == FSM_FN_LARGEST_MAGNITUDE_OP);
  end

  // ----------------------------------------------------------------
  // Operand classification
  // ----------------------------------------------------------------
  // Single values live in the low word; the upper word is ignored.
  logic        a_sign;
  logic        b_sign;
  logic [62:0] a_mag;
  logic [62:0] b_mag;
  logic        a_nan;
  logic        b_nan;
  logic        a_snan;
  logic        b_snan;

  always_comb begin
    if (is_dbl) begin
      a_sign = REQ.first[FSM_D_SIGN];
      b_sign = REQ.second[FSM_D_SIGN];
      a_mag  = REQ.first[62:0];
      b_mag  = REQ.second[62:0];
      a_nan  = (&REQ.first[62:FSM_D_EXP_LO]) && (|REQ.first[FSM_D_EXP_LO-1:0]);
      b_nan  = (&REQ.second[62:FSM_D_EXP_LO]) && (|REQ.second[FSM_D_EXP_LO-1:0]);
      a_snan = a_nan && !REQ.first[FSM_D_QBIT];
      b_snan = b_nan && !REQ.second[FSM_D_QBIT];
    end else begin
      a_sign = REQ.first[FSM_S_SIGN];
      b_sign = REQ.second[FSM_S_SIGN];
      a_mag  = {32'h0000_0000, REQ.first[30:0]};
      b_mag  = {32'h0000_0000, REQ.second[30:0]};
      a_nan  = (&REQ.first[30:FSM_S_EXP_LO]) && (|REQ.first[FSM_S_EXP_LO-1:0]);
      b_nan  = (&REQ.second[30:FSM_S_EXP_LO]) && (|REQ.second[FSM_S_EXP_LO-1:0]);
      a_snan = a_nan && !REQ.first[FSM_S_QBIT];
      b_snan = b_nan && !REQ.second[FSM_S_QBIT];
    end
  end

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  logic a_greater;
  logic a_mag_gt;
  logic pick_a;

  always_comb begin
    // Sign-magnitude ordering; two zeros of opposite sign order -0 below +0.
    if (a_sign != b_sign) begin
      a_greater = b_sign;
    end else if (a_sign) begin
      a_greater = a_mag < b_mag;
    end else begin
      a_greater = a_mag > b_mag;
    end
    a_mag_gt = a_mag > b_mag;
    // A signalling NaN counts as any NaN here, so it is never quieted.
    if (a_nan && b_nan) begin
      pick_a = 1'b1;
    end else if (a_nan) begin
      pick_a = 1'b0;
    end else if (b_nan) begin
      pick_a = 1'b1;
    end else if (is_mag && (a_mag != b_mag)) begin
      pick_a = is_max ? a_mag_gt : !a_mag_gt;
    end else begin
      pick_a = is_max ? a_greater : !a_greater;
    end
  end

  // ----------------------------------------------------------------
  // Result and exception registers
  // ----------------------------------------------------------------
  logic [FSM_DATA_W-1:0] sel_val;
  logic                  any_snan;

  always_comb begin
    sel_val  = pick_a ? REQ.first : REQ.second;
    if (!is_dbl) begin
      sel_val = {32'h0000_0000, sel_val[31:0]};
    end
    any_snan = a_snan || b_snan;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DONE <= 1'b0;
    end else begin
      DONE <= REQ_VALID && is_op;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      EXC <= FSM_EXC_NONE;
    end else begin
      EXC <= FSM_EXC_NONE;
      if (REQ_VALID && is_op) begin
        if (!COP1_ENABLE) begin
          EXC.cop_unusable <= 1'b1;
        end else if (!fmt_ok) begin
          EXC.reserved_instr <= 1'b1;
        end else if (any_snan) begin
          EXC.invalid_cause <= 1'b1;
          EXC.invalid_trap  <= INVALID_ENABLE;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WB <= '0;
    end else begin
      WB.wr_en <= 1'b0;
      // A trapped request leaves dest and data alone, so they only move with a write.
      if (REQ_VALID && is_op && COP1_ENABLE && fmt_ok && !(any_snan && INVALID_ENABLE)) begin
        WB.wr_en <= 1'b1;
        WB.dest  <= REQ.dest;
        WB.data  <= sel_val;
      end
    end
  end

endmodule

// >>> logic/fsm_pkg.sv
package fsm_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int         FSM_FMT_W      = 5;
  localparam int         FSM_FUNCT_W    = 6;
  localparam int         FSM_REG_W      = 5;
  localparam int         FSM_DATA_W     = 64;
  localparam logic [4:0] FSM_FMT_SINGLE = 5'h10;
  localparam logic [4:0] FSM_FMT_DOUBLE = 5'h11;
  localparam logic [5:0] FSM_FN_MIN     = 6'h1C;
  localparam logic [5:0] FSM_FN_SMALLEST_MAGNITUDE_OP    = 6'h1D;
  localparam logic [5:0] FSM_FN_MAX     = 6'h1E;
  localparam logic [5:0] FSM_FN_LARGEST_MAGNITUDE_OP    = 6'h1F;

  // ----------------------------------------------------------------
  // Format layouts
  // ----------------------------------------------------------------
  localparam int         FSM_S_SIGN     = 31;
  localparam int         FSM_S_EXP_LO   = 23;
  localparam int         FSM_S_QBIT     = 22;
  localparam int         FSM_D_SIGN     = 63;
  localparam int         FSM_D_EXP_LO   = 52;
  localparam int         FSM_D_QBIT     = 51;
  localparam int         FSM_MIN_REV    = 6;

  // ----------------------------------------------------------------
  // Request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FSM_FUNCT_W-1:0] funct;
    logic [FSM_FMT_W-1:0]   fmt;
    logic [FSM_REG_W-1:0]   dest;
    logic [FSM_DATA_W-1:0]  first;
    logic [FSM_DATA_W-1:0]  second;
  } fsm_req_s;

  typedef struct packed {
    logic                   wr_en;
    logic [FSM_REG_W-1:0]   dest;
    logic [FSM_DATA_W-1:0]  data;
  } fsm_wb_s;

  typedef struct packed {
    logic cop_unusable;
    logic reserved_instr;
    logic invalid_trap;
    logic invalid_cause;
    logic unimpl_cause;
  } fsm_exc_s;

  localparam logic [4:0] FSM_EXC_NONE = 5'h00;

endpackage

// >>> verif/fsm_fpr_model.sv
`timescale 1ns/10ps
module fsm_fpr_model
  import fsm_pkg::*;
(
  // Write-back from the unit
  input logic    clk,
  input fsm_wb_s wb
);
  // ----------------
  // Register file
  // ----------------
  // Only pulsed writes land, so a lost dest field shows up as a stale entry.
  logic [FSM_DATA_W-1:0] fpr [32];
  always_ff @(posedge clk) begin
    if (wb.wr_en) begin
      fpr[wb.dest] <= wb.data;
    end
  end
endmodule

// >>> verif/fsm_minmax_unit_sva.sv
`timescale 1ns/10ps
module fsm_minmax_unit_sva
  import fsm_pkg::*;
#(parameter int ARCH_REV = 6) (
  // Clock, reset, control
  input logic     CORE_CLK,
  input logic     RST,
  input logic     COP1_ENABLE,
  input logic     INVALID_ENABLE,
  input logic     DOUBLE_IMPL,
  // Request and answer
  input logic     REQ_VALID,
  input fsm_req_s REQ,
  input fsm_wb_s  WB,
  input logic     DONE,
  input fsm_exc_s EXC
);
  // ----------------
  // Checks
  // ----------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire mm  = REQ_VALID && REQ.funct[5:2] == 4'h7 && ARCH_REV >= 6;
  wire fok = REQ.fmt == FSM_FMT_SINGLE || (REQ.fmt == FSM_FMT_DOUBLE && DOUBLE_IMPL);
  AST_DONE: assert property (mm |=> DONE) else $error("done missing");
  AST_IDLE: assert property (!REQ_VALID |=> !DONE && !WB.wr_en && EXC == FSM_EXC_NONE)
    else $error("output without request");
  AST_COP: assert property (mm && !COP1_ENABLE |=> EXC.cop_unusable && !WB.wr_en)
    else $error("coprocessor off not refused");
  AST_FMT: assert property (mm && COP1_ENABLE && !fok |=> EXC.reserved_instr && !WB.wr_en)
    else $error("bad format not refused");
  AST_TRAP: assert property (EXC.invalid_trap |-> EXC.invalid_cause && !WB.wr_en)
    else $error("trap with write");
  AST_NOTRAP: assert property (EXC.invalid_cause && !$past(INVALID_ENABLE) |-> WB.wr_en)
    else $error("quiet invalid lost write");
  AST_DEST: assert property (WB.wr_en |-> WB.dest == $past(REQ.dest))
    else $error("wrong destination");
  AST_HOLD: assert property (!WB.wr_en |-> $stable(WB.data))
    else $error("data moved without write");
  AST_SGL: assert property (WB.wr_en && $past(REQ.fmt) == FSM_FMT_SINGLE |-> WB.data[63:32] == 32'h0)
    else $error("single result upper half set");
endmodule
bind fsm_minmax_unit fsm_minmax_unit_sva #(.ARCH_REV(ARCH_REV)) u_sva (.CORE_CLK, .RST, .COP1_ENABLE,
  .INVALID_ENABLE, .DOUBLE_IMPL, .REQ_VALID, .REQ, .WB, .DONE, .EXC);

// >>> verif/fsm_minmax_unit_tb.sv
`timescale 1ns/10ps
module fsm_minmax_unit_tb;
  import fsm_pkg::*;
  logic        clk = 0, rst = 1, cop = 1, inv = 0, dimpl = 1, valid = 0, done;
  fsm_req_s    req = '0;
  fsm_wb_s     wb;
  fsm_exc_s    exc;
  logic [31:0] lf = 32'h0000E2C7;
  int          n_mismatch = 0, tests_run = 0;
  fsm_minmax_unit u_fsm_minmax_unit (.CORE_CLK(clk), .RST(rst), .COP1_ENABLE(cop), .INVALID_ENABLE(inv),
    .DOUBLE_IMPL(dimpl), .REQ_VALID(valid), .REQ(req), .WB(wb), .DONE(done), .EXC(exc));
  fsm_fpr_model u_fsm_fpr_model (.clk(clk), .wb(wb));
  initial forever #50 clk = ~clk;
  // ----------------
  // Model
  // ----------------
  function automatic logic [31:0] nxt();
    lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04C11DB7 : 32'h0);
    return lf;
  endfunction
  // Returns 2 for a quiet NaN, 3 for a signalling one.
  function automatic logic [1:0] nan_of(logic d, logic [63:0] v);
    logic n;
    n = d ? v[62:0] > 63'h7FF0000000000000 : v[30:0] > 31'h7F800000;
    return {n, n && !(d ? v[51] : v[22])};
  endfunction
  function automatic logic [63:0] ref_sel(logic [5:0] f, logic d, logic [63:0] a, logic [63:0] b);
    longint ma, mb, ka, kb;
    logic   big;
    if (nan_of(d, a) > 1) return nan_of(d, b) > 1 ? a : b;
    if (nan_of(d, b) > 1) return a;
    ma = d ? a[62:0] : a[30:0];
    mb = d ? b[62:0] : b[30:0];
    ka = (d ? a[63] : a[31]) ? -ma : ma;
    kb = (d ? b[63] : b[31]) ? -mb : mb;
    big = ka > kb || (ka == kb && ka >= 0 && !(d ? a[63] : a[31]));
    if (f[0] && ma != mb) big = ma > mb;
    return (f[1] ~^ big) ? a : b;
  endfunction
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    logic [63:0] a, b, sg, nn;
    logic        d, bad, sn, wr, mm;
    logic [4:0]  ex;
    repeat (12) @(negedge clk);
    rst = 0;
    repeat (600) begin
      @(negedge clk);
      d = nxt() & 1;
      sg = d ? 64'h8000000000000000 : 64'h80000000;
      nn = d ? 64'h7FF0000000000000 : 64'h7F800000;
      req.fmt = lf[3:1] == 0 ? 5'h14 : d ? FSM_FMT_DOUBLE : FSM_FMT_SINGLE;
      req.funct = lf[6:4] == 0 ? 6'h05 : {4'h7, lf[8:7]};
      req.dest = lf[13:9];
      cop = lf[16:14] != 0;
      inv = lf[17];
      dimpl = lf[20:18] != 0;
      a = {nxt(), nxt()};
      if (lf[1:0] == 0) a &= sg;
      if (lf[3:2] == 0) a |= nn;
      b = lf[5:4] == 0 ? a ^ sg : {nxt(), nxt()};
      if (lf[7:6] == 0) b |= nn;
      a[63:32] &= {32{d}};
      b[63:32] &= {32{d}};
      req.first = a;
      req.second = b;
      valid = 1;
      // The answer pulses stand for one cycle only, so they are looked at one negedge later.
      @(negedge clk);
      mm = req.funct[5:2] == 4'h7;
      bad = req.fmt != FSM_FMT_SINGLE && !(req.fmt == FSM_FMT_DOUBLE && dimpl);
      sn = nan_of(d, a) == 3 || nan_of(d, b) == 3;
      ex = !mm ? 5'h00 : !cop ? 5'h10 : bad ? 5'h08 : {2'b00, sn && inv, sn, 1'b0};
      wr = mm && cop && !bad && !(sn && inv);
      chk("DONE", 64'(mm), 64'(done));
      chk("EXC", 64'(ex), 64'(exc));
      chk("WR", 64'(wr), 64'(wb.wr_en));
      valid = 0;
      @(negedge clk);
      if (wr) chk("FPR", ref_sel(req.funct, d, a, b), u_fsm_fpr_model.fpr[req.dest]);
    end
    print_verdict();
  end
  initial begin
    #(100 * 4 * 700);
    n_mismatch++;
    print_verdict();
  end
endmodule
